// File: rtl/branch_unit.sv
/*
  Branch unit: branch execute, mispredict recovery and branch writeback
  stages, static prediction, delayed purge, predicted-branch tag and link
  shadow registers.
  Assumes dispatch, fetch, the instruction queue and integer completion run
  on the same clock, and that dispatch only issues a branch conditional on
  the condition register while accept_cr_r is high and a link- or
  count-updating branch while accept_wb_r is high.
*/
// What this block does
// - Every branch spends exactly one execute cycle
// - Compute target; resolve if coherent, else predict
// - CR-conditional branch enters recovery with execute
// - Resolved leaves recovery after one cycle
// - Non-CR branches bypass a busy recovery stage
// - Writeback stage holds up to nine branches
// - Leave writeback only after tag leaves completion
// - Only link/count updaters enter writeback
// - Static prediction from branch direction, hint bit inverts
// - Store alternate path; clear on correct prediction
// - Mispredict: redirect fetch, purge queued wrong path
// - Recovery and writeback occupancy tracked independently
// - Correct prediction: purge waits for target load
// - Early mispredict keeps sequential, drops target
// - No dispatch onto predicted tag or CR branch
// - Predicted tag stops at integer execute
// - Mispredict purges younger; correct deletes tag
// - Only one predicted branch outstanding
// - Link value in shadow, freed after writeback
// - Unconditional branches write back only with link
// - Target fetch requested in the cycle after execute
// - Resolved condition read in combined execute cycle
// - Condition read ends the recovery stay
// - Return-to-link uses newest shadow link value
`timescale 1ns/1ps

module branch_unit
  import branch_unit_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Branch from dispatch into the branch execute stage
  input  wire logic              disp_valid,
  input  wire br_kind_e          disp_kind,
  input  wire logic              disp_cond_on_cr,
  input  wire logic              disp_count_ok,
  input  wire logic              disp_hint,
  input  wire logic              disp_link_bit,
  input  wire logic              disp_dec_count,
  input  wire logic [ADDR_W-1:0] disp_pc,
  input  wire logic [ADDR_W-1:0] disp_offset,
  // Condition register
  input  wire logic              cr_coherent,
  input  wire logic              cr_taken,
  input  wire logic              cr_resolve,
  // Architected link and count registers
  input  wire logic [ADDR_W-1:0] link_register_q,
  input  wire logic [ADDR_W-1:0] count_register_q,
  // Integer completion and instruction queue
  input  wire logic              ic_tag_leave,
  input  wire logic              iq_target_written,
  // Acceptance toward dispatch
  output logic                   accept_cr_r,
  output logic                   accept_wb_r,
  output logic                   no_fold_r,
  // Fetch and instruction queue control
  output logic                   fetch_req_r,
  output logic [ADDR_W-1:0]      fetch_addr_r,
  output logic                   iq_purge_r,
  output logic                   target_cancel_r,
  output logic                   delayed_purge_r,
  // Predicted-branch tag toward the integer pipeline
  output logic                   pred_tag_r,
  output logic                   pred_tag_delete_r,
  output logic                   spec_purge_r,
  // Register writeback and status
  output logic                   link_wr_r,
  output logic [ADDR_W-1:0]      link_wr_data_r,
  output logic                   count_wr_r,
  output logic [ADDR_W-1:0]      count_wr_data_r,
  output logic                   mr_busy_r,
  output logic [BW_CNT_W-1:0]    bw_count_r
);

  typedef struct packed {
    logic                          mr_valid;
    logic                          mr_resolved;
    logic                          mr_taken;
    logic                          mr_predicted;
    logic                          mr_pred_taken;
    logic                          tgt_loaded;
    logic                          wait_purge;
    logic                          pred_tag;
    logic [ADDR_W-1:0]             mr_alt;
    logic [SHADOW_CNT-1:0]         sh_valid;
    logic [SHADOW_CNT-1:0][31:0]   shadow;
    logic                          newest;
    logic                          rel_valid;
    logic                          rel_idx;
    logic [BW_CNT_W-1:0]           bw_cnt;
    bw_entry_s [BW_DEPTH-1:0]      bw;
    logic                          accept_cr;
    logic                          accept_wb;
    logic                          no_fold;
    logic                          fetch_req;
    logic [ADDR_W-1:0]             fetch_addr;
    logic                          iq_purge;
    logic                          target_cancel;
    logic                          delayed_purge;
    logic                          pred_tag_delete;
    logic                          spec_purge;
    logic                          link_wr;
    logic [ADDR_W-1:0]             link_wr_data;
    logic                          count_wr;
    logic [ADDR_W-1:0]             count_wr_data;
  } state_s;

  state_s            state_r;
  state_s            state_nxt;
  logic              resolve_now;
  logic              taken_now;
  logic              target_seen;
  logic [ADDR_W-1:0] target;
  logic [ADDR_W-1:0] seq_addr;
  logic [ADDR_W-1:0] look_link;
  logic              backward;
  logic              pred_dir;
  logic              go_taken;
  logic              needs_wb;
  logic              free_idx;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.fetch_req       = 1'b0;
    state_nxt.iq_purge        = 1'b0;
    state_nxt.target_cancel   = 1'b0;
    state_nxt.delayed_purge   = 1'b0;
    state_nxt.pred_tag_delete = 1'b0;
    state_nxt.spec_purge      = 1'b0;
    state_nxt.link_wr         = 1'b0;
    state_nxt.count_wr        = 1'b0;
    target_seen = state_r.tgt_loaded | iq_target_written;
    seq_addr    = disp_pc + INSN_BYTES;
    look_link = state_r.sh_valid[state_r.newest] ? state_r.shadow[state_r.newest]
                                                  : link_register_q;

    // shadow freed the cycle after its link write
    if (state_r.rel_valid) begin
      state_nxt.sh_valid[state_r.rel_idx] = 1'b0;
      state_nxt.rel_valid = 1'b0;
    end

    // retire oldest entry when its tag leaves completion
    if (ic_tag_leave && state_r.bw_cnt != '0) begin
      state_nxt.link_wr       = state_r.bw[0].upd_link;
      state_nxt.link_wr_data  = state_r.shadow[state_r.bw[0].sh_idx];
      state_nxt.rel_valid     = state_r.bw[0].upd_link;
      state_nxt.rel_idx       = state_r.bw[0].sh_idx;
      state_nxt.count_wr      = state_r.bw[0].upd_count;
      state_nxt.count_wr_data = state_r.bw[0].count_val;
      for (int i = 0; i < BW_DEPTH - 1; i++) begin
        state_nxt.bw[i] = state_r.bw[i + 1];
      end
      state_nxt.bw[BW_DEPTH-1] = '0;
      state_nxt.bw_cnt = state_r.bw_cnt - 4'h1;
    end

    if (state_r.mr_valid && iq_target_written) begin
      state_nxt.tgt_loaded = 1'b1;
    end

    // delayed purge once the target has arrived
    if (state_r.wait_purge && iq_target_written) begin
      state_nxt.delayed_purge = 1'b1;
      state_nxt.wait_purge    = 1'b0;
    end

    // condition read ends the recovery stay
    resolve_now = state_r.mr_valid & (state_r.mr_resolved | cr_resolve);
    taken_now   = state_r.mr_resolved ? state_r.mr_taken : cr_taken;
    if (resolve_now) begin
      state_nxt.mr_valid = 1'b0;
      if (state_r.mr_predicted) begin
        state_nxt.pred_tag = 1'b0;
        if (taken_now == state_r.mr_pred_taken) begin
          state_nxt.pred_tag_delete = 1'b1;
          if (state_r.mr_pred_taken && target_seen) begin
            state_nxt.delayed_purge = 1'b1;
          end else if (state_r.mr_pred_taken) begin
            state_nxt.wait_purge = 1'b1;
          end
        end else if (state_r.mr_pred_taken && !target_seen) begin
          state_nxt.target_cancel = 1'b1;
          state_nxt.spec_purge    = 1'b1;
        end else begin
          state_nxt.fetch_req  = 1'b1;
          state_nxt.fetch_addr = state_r.mr_alt;
          state_nxt.iq_purge   = 1'b1;
          state_nxt.spec_purge = 1'b1;
        end
      end
    end

    unique case (disp_kind)
      KIND_REL:      target = disp_pc + disp_offset;
      KIND_ABS:      target = disp_offset;
      KIND_TO_LINK:  target = look_link;
      KIND_TO_COUNT: target = count_register_q;
    endcase

    // static prediction with hint inversion
    // Relative direction from the displacement sign, so a wrapping target stays backward
    backward = (disp_kind == KIND_REL) ? disp_offset[ADDR_W-1]
                                       : (disp_kind == KIND_ABS) && (target < disp_pc);
    pred_dir = disp_hint ^ backward;
    go_taken = disp_cond_on_cr ? (cr_coherent ? cr_taken : pred_dir) : disp_count_ok;
    needs_wb = disp_link_bit | disp_dec_count;
    free_idx = state_nxt.sh_valid[0];

    // one execute cycle, results shown in the following cycle
    if (disp_valid) begin
      if (go_taken) begin
        state_nxt.fetch_req  = 1'b1;
        state_nxt.fetch_addr = target;
      end
      // CR branch enters recovery with execute
      if (disp_cond_on_cr) begin
        state_nxt.mr_valid   = 1'b1;
        state_nxt.tgt_loaded = 1'b0;
        // coherent condition read now, leaves next cycle
        state_nxt.mr_resolved  = cr_coherent;
        state_nxt.mr_taken     = cr_taken;
        state_nxt.mr_predicted = ~cr_coherent;
        // hold alternate path and resolution data
        state_nxt.mr_pred_taken = pred_dir;
        state_nxt.mr_alt        = pred_dir ? seq_addr : target;
        // tag raised toward the integer pipeline
        state_nxt.pred_tag      = ~cr_coherent;
      end
      // link value parked in a free shadow
      if (disp_link_bit) begin
        state_nxt.sh_valid[free_idx] = 1'b1;
        state_nxt.shadow[free_idx]   = seq_addr;
        state_nxt.newest             = free_idx;
      end
      // unconditional branches queue only with link
      if (needs_wb && state_nxt.bw_cnt < BW_FULL) begin
        state_nxt.bw[state_nxt.bw_cnt].upd_link  = disp_link_bit;
        state_nxt.bw[state_nxt.bw_cnt].sh_idx    = free_idx;
        state_nxt.bw[state_nxt.bw_cnt].upd_count = disp_dec_count;
        state_nxt.bw[state_nxt.bw_cnt].count_val = count_register_q - COUNT_STEP;
        state_nxt.bw_cnt = state_nxt.bw_cnt + 4'h1;
      end
    end

    // one prediction at a time; resolved stays one cycle
    state_nxt.accept_cr = ~state_nxt.mr_valid;
    // full writeback or no free shadow stalls
    state_nxt.accept_wb = (state_nxt.bw_cnt < BW_FULL) & ~(&state_nxt.sh_valid);
    // no dispatch onto tag or CR branch
    state_nxt.no_fold = state_nxt.pred_tag | (disp_valid & disp_cond_on_cr);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // reset empties every stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // acceptance of non-CR branches is independent of recovery
  assign accept_cr_r       = state_r.accept_cr;
  assign accept_wb_r       = state_r.accept_wb;
  assign no_fold_r         = state_r.no_fold;
  assign fetch_req_r       = state_r.fetch_req;
  assign fetch_addr_r      = state_r.fetch_addr;
  assign iq_purge_r        = state_r.iq_purge;
  assign target_cancel_r   = state_r.target_cancel;
  assign delayed_purge_r   = state_r.delayed_purge;
  assign pred_tag_r        = state_r.pred_tag;
  assign pred_tag_delete_r = state_r.pred_tag_delete;
  assign spec_purge_r      = state_r.spec_purge;
  assign link_wr_r         = state_r.link_wr;
  assign link_wr_data_r    = state_r.link_wr_data;
  assign count_wr_r        = state_r.count_wr;
  assign count_wr_data_r   = state_r.count_wr_data;
  assign mr_busy_r         = state_r.mr_valid;
  assign bw_count_r        = state_r.bw_cnt;

endmodule

// File: rtl/branch_unit_pkg.sv
/*
  Shared constants and types of the branch unit pipeline.
  Assumes 32-bit instruction addresses and 4-byte instructions.
*/
package branch_unit_pkg;

  // ------------------------------------------------------------
  // Widths and depths
  // ------------------------------------------------------------
  localparam int          ADDR_W     = 32;
  localparam int          BW_DEPTH   = 9;
  localparam int          BW_CNT_W   = 4;
  localparam logic [3:0]  BW_FULL    = 4'h9;
  localparam int          SHADOW_CNT = 2;
  localparam logic [31:0] INSN_BYTES = 32'h0000_0004;
  localparam logic [31:0] COUNT_STEP = 32'h0000_0001;

  // ------------------------------------------------------------
  // Branch target kinds
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_REL      = 2'b00,
    KIND_ABS      = 2'b01,
    KIND_TO_LINK  = 2'b10,
    KIND_TO_COUNT = 2'b11
  } br_kind_e;

  // One branch waiting in the branch writeback stage
  typedef struct packed {
    logic        upd_link;
    logic        sh_idx;
    logic        upd_count;
    logic [31:0] count_val;
  } bw_entry_s;

endpackage

// File: verif/branch_unit_properties.sv
/*
  Port-level checks of the branch unit.
  Assumes one clock domain; bound to every instance of the unit.
*/
`timescale 1ns/1ps

module branch_unit_checker
  import branch_unit_pkg::*;
(
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst_n,
  // Watched inputs
  input wire logic                disp_valid,
  input wire logic                disp_cond_on_cr,
  input wire logic                disp_link_bit,
  input wire logic                disp_dec_count,
  input wire logic                cr_coherent,
  input wire logic                cr_resolve,
  input wire logic                ic_tag_leave,
  // Watched outputs
  input wire logic                accept_cr_r,
  input wire logic                accept_wb_r,
  input wire logic                pred_tag_r,
  input wire logic                link_wr_r,
  input wire logic                count_wr_r,
  input wire logic                mr_busy_r,
  input wire logic [BW_CNT_W-1:0] bw_count_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  wb_push_a: assert property (
    disp_valid && (disp_link_bit || disp_dec_count) && !ic_tag_leave && bw_count_r != BW_FULL
    |=> bw_count_r == $past(bw_count_r) + 4'h1) else $error("writeback count did not grow");
  wb_skip_a: assert property (
    disp_valid && !disp_link_bit && !disp_dec_count && !ic_tag_leave
    |=> $stable(bw_count_r)) else $error("plain branch entered writeback");
  wb_after_tag_a: assert property (
    link_wr_r || count_wr_r |-> $past(ic_tag_leave)) else $error("write without tag");
  wb_full_a: assert property (
    bw_count_r >= BW_FULL |-> bw_count_r == BW_FULL && !accept_wb_r)
    else $error("full writeback stage not stalled");
  mr_resolved_a: assert property (
    disp_valid && disp_cond_on_cr && cr_coherent |=> mr_busy_r && !pred_tag_r ##1 !mr_busy_r)
    else $error("resolved branch stay wrong");
  mr_hold_a: assert property (
    pred_tag_r && !cr_resolve |=> pred_tag_r && mr_busy_r) else $error("left recovery early");
  resolve_a: assert property (
    pred_tag_r && cr_resolve |=> !pred_tag_r && !mr_busy_r && accept_cr_r)
    else $error("recovery not cleared");
  one_tag_a: assert property (
    pred_tag_r |-> !accept_cr_r) else $error("second prediction allowed");
endmodule

bind branch_unit branch_unit_checker branch_unit_checker_inst (
  .clk(clk), .rst_n(rst_n), .disp_valid(disp_valid), .disp_cond_on_cr(disp_cond_on_cr),
  .disp_link_bit(disp_link_bit), .disp_dec_count(disp_dec_count), .cr_coherent(cr_coherent),
  .cr_resolve(cr_resolve), .ic_tag_leave(ic_tag_leave), .accept_cr_r(accept_cr_r),
  .accept_wb_r(accept_wb_r), .pred_tag_r(pred_tag_r), .link_wr_r(link_wr_r),
  .count_wr_r(count_wr_r), .mr_busy_r(mr_busy_r), .bw_count_r(bw_count_r));

// File: verif/completion_model.sv
/*
  Integer completion model: releases one link/count tag at a time.
  Assumes the bench raises hold to let the writeback stage fill.
*/
`timescale 1ns/1ps

module completion_model
  import branch_unit_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Bench control and view of the unit
  input  wire logic                hold,
  input  wire logic                slow,
  input  wire logic [BW_CNT_W-1:0] bw_count_r,
  // Tag release
  output logic                     ic_tag_leave
);
  logic [2:0] gap_r;

  // Idle gap after each release so a stale count never causes an extra tag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ic_tag_leave <= 1'b0;
      gap_r        <= 3'h0;
    end else if (ic_tag_leave) begin
      ic_tag_leave <= 1'b0;
      gap_r        <= slow ? 3'h5 : 3'h1;
    end else if (gap_r != 3'h0) begin
      gap_r <= gap_r - 3'h1;
    end else begin
      ic_tag_leave <= !hold && (bw_count_r != '0);
    end
  end
endmodule

// File: verif/branch_unit_tb.sv
/*
  Bench of the branch unit with queue models of writeback and shadows.
  Assumes the checker and completion model are compiled before it.
*/
`timescale 1ns/1ps

module branch_unit_tb;
  import branch_unit_pkg::*;

  // ------------------------------
  // Signals and model state
  // ------------------------------
  logic clk, rst_n, disp_valid, disp_cond_on_cr, disp_count_ok, disp_hint, disp_link_bit;
  logic disp_dec_count, cr_coherent, cr_taken, cr_resolve, ic_tag_leave, iq_target_written;
  logic hold, slow, accept_cr_r, accept_wb_r, no_fold_r, fetch_req_r, iq_purge_r, p, ok, tw;
  logic target_cancel_r, delayed_purge_r, pred_tag_r, pred_tag_delete_r, spec_purge_r, rd;
  logic link_wr_r, count_wr_r, mr_busy_r;
  br_kind_e k, disp_kind;
  logic [BW_CNT_W-1:0] bw_count_r;
  logic [31:0] disp_pc, disp_offset, link_register_q, count_register_q, fetch_addr_r, off;
  logic [31:0] link_wr_data_r, count_wr_data_r, seed, t, pc, r;
  logic [32:0] e;
  logic [32:0] wbq[$];
  logic [31:0] shq[$];
  int err_total, n_compared;

  branch_unit branch_unit_inst (.clk(clk), .rst_n(rst_n), .disp_valid(disp_valid),
    .disp_kind(disp_kind), .disp_cond_on_cr(disp_cond_on_cr), .disp_count_ok(disp_count_ok),
    .disp_hint(disp_hint), .disp_link_bit(disp_link_bit), .disp_dec_count(disp_dec_count),
    .disp_pc(disp_pc), .disp_offset(disp_offset), .cr_coherent(cr_coherent),
    .cr_taken(cr_taken), .cr_resolve(cr_resolve), .link_register_q(link_register_q),
    .count_register_q(count_register_q), .ic_tag_leave(ic_tag_leave),
    .iq_target_written(iq_target_written), .accept_cr_r(accept_cr_r),
    .accept_wb_r(accept_wb_r), .no_fold_r(no_fold_r), .fetch_req_r(fetch_req_r),
    .fetch_addr_r(fetch_addr_r), .iq_purge_r(iq_purge_r), .target_cancel_r(target_cancel_r),
    .delayed_purge_r(delayed_purge_r), .pred_tag_r(pred_tag_r),
    .pred_tag_delete_r(pred_tag_delete_r), .spec_purge_r(spec_purge_r),
    .link_wr_r(link_wr_r), .link_wr_data_r(link_wr_data_r), .count_wr_r(count_wr_r),
    .count_wr_data_r(count_wr_data_r), .mr_busy_r(mr_busy_r), .bw_count_r(bw_count_r));
  completion_model completion_model_inst (.clk(clk), .rst_n(rst_n), .hold(hold),
    .slow(slow), .bw_count_r(bw_count_r), .ic_tag_leave(ic_tag_leave));

  // ------------------------------
  // Helpers
  // ------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] tgt(br_kind_e kd, logic [31:0] a, o);
    case (kd)
      KIND_REL: return a + o;
      KIND_ABS: return o;
      KIND_TO_LINK: return (shq.size() != 0) ? shq[$] : link_register_q;
      default: return count_register_q;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Flags are {cond_on_cr, count_ok, hint, link_bit, dec_count}
  task automatic br(input br_kind_e kd, input logic [4:0] f, input logic [31:0] a, o);
    @(posedge clk);
    disp_valid <= 1'b1;
    disp_kind <= kd;
    {disp_cond_on_cr, disp_count_ok, disp_hint, disp_link_bit, disp_dec_count} <= f;
    {disp_pc, disp_offset} <= {a, o};
    if (f[1]) wbq.push_back({1'b1, a + INSN_BYTES});
    if (f[1]) shq.push_back(a + INSN_BYTES);
    if (f[0]) wbq.push_back({1'b0, count_register_q - COUNT_STEP});
    @(posedge clk);
    disp_valid <= 1'b0;
    count_register_q <= rnd() & 32'hffff_fffc;
    #1;
  endtask

  task automatic res(input logic tk);
    @(posedge clk);
    cr_resolve <= 1'b1;
    cr_taken <= tk;
    @(posedge clk);
    cr_resolve <= 1'b0;
    #1;
  endtask

  // Every register write is compared with the oldest queued branch
  // Sampled mid-cycle so the write pulses have settled
  always @(negedge clk) begin
    if (rst_n && (link_wr_r | count_wr_r) === 1'b1) begin
      e = (wbq.size() != 0) ? wbq.pop_front() : 33'h0;
      chk("wb write", {link_wr_r, link_wr_r ? link_wr_data_r : count_wr_data_r}, e);
      if (link_wr_r && shq.size() != 0) shq.delete(0);
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #50us;
    err_total++;
    give_verdict();
  end

  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    {rst_n, disp_valid, disp_cond_on_cr, disp_count_ok, disp_hint, disp_link_bit} = '0;
    {disp_dec_count, cr_coherent, cr_taken, cr_resolve, iq_target_written, hold, slow} = '0;
    disp_kind = KIND_REL;
    {disp_pc, disp_offset} = '0;
    seed = 32'h0000_002d;
    link_register_q = rnd() & 32'hffff_fffc;
    count_register_q = rnd() & 32'hffff_fffc;
    repeat (8) @(posedge clk);
    chk("reset", {accept_cr_r, accept_wb_r, mr_busy_r, pred_tag_r, bw_count_r}, 0);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("idle", {accept_cr_r, accept_wb_r, mr_busy_r, pred_tag_r}, 4'hc);
    cr_coherent <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      cr_taken <= i[0];
      br(KIND_REL, 5'b10000, 32'h0000_0800, 32'h0000_0100);
      chk("resolved", {fetch_req_r, mr_busy_r, pred_tag_r}, {i[0], 2'b10});
      chk("target", fetch_addr_r & {32{i[0]}}, 32'h0000_0900 & {32{i[0]}});
    end
    cr_coherent <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      k = br_kind_e'(i[1:0]);
      pc = rnd() & 32'h00ff_fffc;
      off = rnd() & 32'hffff_fffc;
      r = rnd();
      t = tgt(k, pc, off);
      p = ((k == KIND_REL) ? off[31] : (k == KIND_ABS && off < pc)) ^ i[2];
      ok = (r[0] == p);
      tw = p & (r[1] | ok);
      rd = !ok && !(p && !tw);
      br(k, {2'b10, i[2], 2'b00}, pc, off);
      chk("predict", {fetch_req_r, fetch_addr_r & {32{p}}}, {p, t & {32{p}}});
      chk("tag", {mr_busy_r, pred_tag_r, no_fold_r, accept_cr_r}, 4'he);
      if (i[3]) begin
        br(KIND_REL, 5'b01000, pc, 32'h0000_0040);
        chk("bypass", {fetch_req_r, mr_busy_r, fetch_addr_r}, {2'b11, pc + 32'h40});
      end
      if (tw) begin
        @(posedge clk);
        iq_target_written <= 1'b1;
        @(posedge clk);
        iq_target_written <= 1'b0;
      end
      res(r[0]);
      chk("outcome", {pred_tag_delete_r, spec_purge_r, delayed_purge_r, target_cancel_r},
          {ok, !ok, ok & p, !ok & p & !tw});
      chk("recover", {fetch_req_r, iq_purge_r, fetch_addr_r & {32{rd}}},
          {rd, rd, (p ? pc + INSN_BYTES : t) & {32{rd}}});
    end
    // Correct taken resolution before the target arrives: purge waits for it
    br(KIND_REL, 5'b10000, 32'h0000_0800, 32'hffff_ff00);
    res(1'b1);
    chk("late target", {pred_tag_delete_r, delayed_purge_r}, 2'b10);
    iq_target_written <= 1'b1;
    @(posedge clk);
    iq_target_written <= 1'b0;
    #1;
    chk("delayed purge", delayed_purge_r, 1);
    hold <= 1'b1;
    br(KIND_REL, 5'b01010, 32'h0000_1000, 32'h0000_0200);
    br(KIND_REL, 5'b10010, 32'h0000_2000, 32'h0000_0100);
    chk("shadows", {accept_wb_r, bw_count_r}, {1'b0, 4'h2});
    t = tgt(KIND_TO_LINK, 32'h0, 32'h0);
    br(KIND_TO_LINK, 5'b01000, 32'h0000_3000, 32'h0);
    chk("lookahead", {fetch_addr_r, bw_count_r}, {t, 4'h2});
    hold <= 1'b0;
    repeat (12) @(posedge clk);
    #1;
    chk("drain in recovery", {bw_count_r, mr_busy_r}, {4'h0, 1'b1});
    res(1'b0);
    {hold, slow} <= 2'b11;
    for (int i = 1; i <= 9; i++) begin
      br(KIND_TO_COUNT, 5'b01001, 32'h0000_4000, 32'h0);
      chk("fill", bw_count_r, i);
    end
    chk("full", accept_wb_r, 0);
    hold <= 1'b0;
    repeat (90) @(posedge clk);
    #1;
    chk("drained", {bw_count_r, accept_wb_r, wbq.size()}, {4'h0, 1'b1, 32'h0});
    give_verdict();
  end
endmodule
